// >>> pkg/gmc_pkg.sv
// Purpose: shared constants and types for the genlock mode control block
// Assumes: mclk_i at 25 MHz, all inputs synchronous to it
// Notes:   times are kept in their own unit, cycle counts derive from them
package gmc_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ          = 25;
    // no h sync edge within this window counts as one h sync error
    localparam int HS_WINDOW_US     = 100;
    localparam int HS_WINDOW_CYC    = HS_WINDOW_US * CLK_MHZ;
    // lock must hold this long before the vcxo counts as stable
    localparam int LOCK_SETTLE_US   = 10;
    localparam int LOCK_SETTLE_CYC  = LOCK_SETTLE_US * CLK_MHZ;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int HERR_W           = 2;
    localparam int ERRCNT_W         = 3;
    localparam int WIN_W            = 12;
    localparam int SETTLE_W         = 9;

    localparam logic [WIN_W-1:0]    WIN_LAST    = WIN_W'(HS_WINDOW_CYC - 1);
    localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(LOCK_SETTLE_CYC - 1);
    localparam logic [ERRCNT_W-1:0] ERR_MAX     = 3'h7;
    localparam logic [ERRCNT_W-1:0] ERR_ZERO    = 3'h0;
    localparam logic [WIN_W-1:0]    WIN_ZERO    = 12'h000;
    localparam logic [SETTLE_W-1:0] SETTLE_ZERO = 9'h000;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    // no reference is known until the first h sync edge
    localparam logic RST_REF_LOSS   = 1'b1;
    localparam logic RST_LOCK_LOSS  = 1'b1;

    // ------------------------------------------------------------
    // genlock states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_FREE     = 3'h0,
        ST_ACQUIRE  = 3'h1,
        ST_LOCKED   = 3'h2,
        ST_LOR_FREE = 3'h3,
        ST_LOR_HOLD = 3'h4
    } gmc_state_e;

endpackage

// >>> pkg/gmc_ref_if.sv
// Purpose: carrier between mode control and the reference monitor
// Assumes: one clock domain
// Notes:   ctl drives the selected h sync and threshold, mon returns status
`timescale 1ns/1ps
`default_nettype none
interface gmc_ref_if;
    import gmc_pkg::*;
    logic              hsync;
    logic [HERR_W-1:0] h_error;
    logic              ref_loss;
    logic              pulse_seen;

    modport ctl (output hsync, output h_error, input ref_loss, input pulse_seen);
    modport mon (input hsync, input h_error, output ref_loss, output pulse_seen);
endinterface
`default_nettype wire

// >>> hw/gmc_ref_monitor.sv
// Purpose: h sync error counting and reference loss flag
// Assumes: hsync is already registered by the caller
// Notes:   one missed window is one error; loss when errors exceed threshold
`timescale 1ns/1ps
`default_nettype none
module gmc_ref_monitor (
    input  wire logic mclk_i,
    input  wire logic srst_i,
    gmc_ref_if.mon    ref_if
);
    import gmc_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic                hs_d;
        logic [WIN_W-1:0]    win_cnt;
        logic [ERRCNT_W-1:0] err_cnt;
        logic                loss;
        logic                seen;
    } gmc_mon_s;

    gmc_mon_s st_reg;
    gmc_mon_s st_next;
    logic     edge_w;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_next      = st_reg;
        edge_w       = ref_if.hsync & ~st_reg.hs_d;
        st_next.hs_d = ref_if.hsync;
        st_next.seen = edge_w;
        if (edge_w) begin
            // any valid edge clears loss and the error history
            st_next.win_cnt = WIN_ZERO; // RULE_19
            st_next.err_cnt = ERR_ZERO;
            st_next.loss    = 1'b0; // RULE_19
        end else if (st_reg.win_cnt == WIN_LAST) begin
            st_next.win_cnt = WIN_ZERO;
            if (st_reg.err_cnt != ERR_MAX) begin
                st_next.err_cnt = st_reg.err_cnt + 3'h1;
            end
            // higher threshold needs more missed windows before loss
            if (st_reg.err_cnt >= ERRCNT_W'(ref_if.h_error)) begin // RULE_17
                st_next.loss = 1'b1; // RULE_19
            end
        end else begin
            st_next.win_cnt = st_reg.win_cnt + 12'h001;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            st_reg <= '{1'b0, WIN_ZERO, ERR_ZERO, RST_REF_LOSS, 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign ref_if.ref_loss   = st_reg.loss;
    assign ref_if.pulse_seen = st_reg.seen;

endmodule
`default_nettype wire

// >>> hw/gmc_top.sv
// Purpose: free-run / genlock / loss-of-reference mode control of PLL 1
// Assumes: inputs synchronous to mclk_i, analog switches driven by outputs
// Notes:   all outputs are flip-flops; status flags follow the state, but reference loss in free run follows the monitor
//
// Notes on behaviour
// RULE_01: mode bit clear runs the reference PLL free, vcxo ignores reference.
// RULE_02: mode bit set enters genlock, tracking selected port h sync.
// RULE_03: source select clear hands the mode choice to the external pin.
// RULE_04: free run keeps output clocks locked to the vcxo clock.
// RULE_05: free run closes the switch from bias input to loop filter node.
// RULE_06: hold select 0 at loss falls back to free run until reference returns.
// RULE_07: hold select 1 at loss enters hold until reference returns.
// RULE_08: returning reference in genlock restarts lock acquisition at once.
// RULE_09: genlock free runs only during loss; free mode always free runs.
// RULE_10: hold puts loop filter output high impedance once loss is flagged.
// RULE_11: genlock tracks the reference without waiting for input stability.
// RULE_12: host programs clocks, frame timing, dividers, mode, then alignment.
// RULE_13: host programs frame timing before genlock even if unused.
// RULE_14: stable lock in genlock permits output and frame pulse alignment.
// RULE_15: alignment is allowed whatever the reference format is.
// RULE_16: every state drives defined reference-loss and lock-loss flags.
// RULE_17: h sync error setting sets loss threshold; higher delays the flag.
// RULE_18: reset starts in free run until genlock is requested.
// RULE_19: loss flag set past error threshold, cleared when h sync returns.
`timescale 1ns/1ps
`default_nettype none
module gmc_top (
    input  wire logic                        mclk_i,
    input  wire logic                        srst_i,
    // mode selection
    input  wire logic                        lock_mode_bit_i,
    input  wire logic                        mode_source_select_i,
    input  wire logic                        mode_select_pin_n_i,
    input  wire logic                        hold_on_loss_i,
    // reference inputs
    input  wire logic                        hsync_a_i,
    input  wire logic                        hsync_b_i,
    input  wire logic                        ref_port_sel_i,
    input  wire logic [gmc_pkg::HERR_W-1:0]  h_error_i,
    // phase detector lock indication
    input  wire logic                        pll_locked_i,
    // loop and switch control
    output logic                             free_bias_sw_o,
    output logic                             lpf_hiz_o,
    output logic                             pd_track_en_o,
    output logic                             pd_hsync_o,
    output logic                             out_align_en_o,
    // status
    output logic                             genlock_mode_o,
    output logic                             reference_loss_o,
    output logic                             lock_loss_o,
    output logic                             lor_event_o,
    output logic                             relock_event_o,
    output logic [2:0]                       state_o
);
    import gmc_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        gmc_state_e          fsm;
        logic                hs_sel;
        logic [HERR_W-1:0]   herr;
        logic [SETTLE_W-1:0] settle;
        logic                genlock;
        logic                bias_sw;
        logic                hiz;
        logic                track;
        logic                pd_hs;
        logic                align;
        logic                ref_loss;
        logic                lock_loss;
        logic                lor_ev;
        logic                relock_ev;
    } gmc_ctl_s;

    gmc_ctl_s  st_reg;
    gmc_ctl_s  st_next;
    gmc_ref_if ref_if ();

    logic       mode_w;
    logic       loss_w;
    gmc_state_e nfsm_w;
    gmc_state_e lor_w;

    // ------------------------------------------------------------
    // reference monitor
    // ------------------------------------------------------------
    assign ref_if.hsync   = st_reg.hs_sel;
    assign ref_if.h_error = st_reg.herr;

    gmc_ref_monitor u_mon (
        .mclk_i (mclk_i),
        .srst_i (srst_i),
        .ref_if (ref_if)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        loss_w  = ref_if.ref_loss;

        // pin is active low: low asks for genlock
        if (mode_source_select_i) begin
            mode_w = lock_mode_bit_i;
        end else begin
            mode_w = ~mode_select_pin_n_i; // RULE_03
        end

        // hold select is taken at the moment loss is seen
        if (hold_on_loss_i) begin
            lor_w = ST_LOR_HOLD; // RULE_07
        end else begin
            lor_w = ST_LOR_FREE; // RULE_06
        end

        st_next.hs_sel = ref_port_sel_i ? hsync_b_i : hsync_a_i;
        st_next.herr   = h_error_i; // RULE_17

        nfsm_w = st_reg.fsm;
        case (st_reg.fsm)
            ST_FREE: begin
                // free mode uses reference loss to pick the state entered when genlock is requested and to drive the reference loss flag
                if (mode_w) begin // RULE_02
                    nfsm_w = loss_w ? lor_w : ST_ACQUIRE;
                end
            end
            ST_ACQUIRE: begin
                if (!mode_w) begin
                    nfsm_w = ST_FREE; // RULE_01
                end else if (loss_w) begin
                    nfsm_w = lor_w;
                end else if (pll_locked_i && st_reg.settle == SETTLE_LAST) begin
                    nfsm_w = ST_LOCKED; // RULE_14
                end
            end
            ST_LOCKED: begin
                if (!mode_w) begin
                    nfsm_w = ST_FREE; // RULE_01
                end else if (loss_w) begin
                    nfsm_w = lor_w;
                end else if (!pll_locked_i) begin
                    nfsm_w = ST_ACQUIRE;
                end
            end
            ST_LOR_FREE, ST_LOR_HOLD: begin
                if (!mode_w) begin
                    nfsm_w = ST_FREE; // RULE_09
                end else if (!loss_w) begin
                    // no holdoff: acquisition restarts the next cycle
                    nfsm_w = ST_ACQUIRE; // RULE_08
                end
            end
            default: begin
                nfsm_w = ST_FREE;
            end
        endcase
        st_next.fsm     = nfsm_w;
        st_next.genlock = mode_w;

        // stability counter runs only while lock holds in acquisition
        if (nfsm_w == ST_ACQUIRE && pll_locked_i && st_reg.fsm == ST_ACQUIRE) begin
            if (st_reg.settle != SETTLE_LAST) begin
                st_next.settle = st_reg.settle + 9'h001;
            end
        end else begin
            st_next.settle = SETTLE_ZERO;
        end

        // outputs decoded from the next state so they align with state_o
        st_next.bias_sw   = 1'b0;
        st_next.hiz       = 1'b0;
        st_next.track     = 1'b0;
        st_next.align     = 1'b0;
        st_next.ref_loss  = loss_w;
        st_next.lock_loss = RST_LOCK_LOSS;
        case (nfsm_w)
            ST_FREE: begin
                // vcxo free; output PLLs keep tracking the vcxo clock
                st_next.bias_sw   = 1'b1; // RULE_05
                st_next.ref_loss  = loss_w; // RULE_16
                st_next.lock_loss = 1'b1; // RULE_04
            end
            ST_ACQUIRE: begin
                // tracking starts even if input timing is still unsettled
                st_next.track     = 1'b1; // RULE_11
                st_next.ref_loss  = 1'b0; // RULE_16
                st_next.lock_loss = 1'b1;
            end
            ST_LOCKED: begin
                // cross-locked formats are not checked against each other
                st_next.track     = 1'b1;
                st_next.align     = 1'b1; // RULE_15
                st_next.ref_loss  = 1'b0; // RULE_16
                st_next.lock_loss = 1'b0;
            end
            ST_LOR_FREE: begin
                st_next.bias_sw   = 1'b1; // RULE_09
                st_next.ref_loss  = 1'b1; // RULE_16
                st_next.lock_loss = 1'b1;
            end
            ST_LOR_HOLD: begin
                // switch stays open so the filter keeps its charge
                st_next.hiz       = 1'b1; // RULE_10
                st_next.ref_loss  = 1'b1; // RULE_16
                st_next.lock_loss = 1'b1;
            end
            default: begin
                st_next.bias_sw   = 1'b1;
            end
        endcase

        // phase detector sees h sync only while tracking
        st_next.pd_hs = st_next.track & st_reg.hs_sel; // RULE_02

        st_next.lor_ev = (nfsm_w == ST_LOR_FREE || nfsm_w == ST_LOR_HOLD)
                       && st_reg.fsm != ST_LOR_FREE && st_reg.fsm != ST_LOR_HOLD;
        st_next.relock_ev = (st_reg.fsm == ST_LOR_FREE || st_reg.fsm == ST_LOR_HOLD)
                          && nfsm_w == ST_ACQUIRE; // RULE_08
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            st_reg           <= '0;
            st_reg.fsm       <= ST_FREE; // RULE_18
            st_reg.bias_sw   <= 1'b1;
            st_reg.ref_loss  <= RST_REF_LOSS;
            st_reg.lock_loss <= RST_LOCK_LOSS;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign free_bias_sw_o   = st_reg.bias_sw;
    assign lpf_hiz_o        = st_reg.hiz;
    assign pd_track_en_o    = st_reg.track;
    assign pd_hsync_o       = st_reg.pd_hs;
    assign out_align_en_o   = st_reg.align;
    assign genlock_mode_o   = st_reg.genlock;
    assign reference_loss_o = st_reg.ref_loss;
    assign lock_loss_o      = st_reg.lock_loss;
    assign lor_event_o      = st_reg.lor_ev;
    assign relock_event_o   = st_reg.relock_ev;
    assign state_o          = st_reg.fsm;

endmodule
`default_nettype wire

// >>> verif/gmc_top_asserts.sv
// Purpose: concurrent checks on the gmc_top ports
// Assumes: single clock, srst_i synchronous active high
// Notes:   decoded outputs tied to state_o, events to transitions
`timescale 1ns/1ps
`default_nettype none
module gmc_top_asserts (
    input  wire logic       mclk_i,
    input  wire logic       srst_i,
    input  wire logic       lock_mode_bit_i,
    input  wire logic       mode_source_select_i,
    input  wire logic       mode_select_pin_n_i,
    input  wire logic       pll_locked_i,
    input  wire logic       free_bias_sw_o,
    input  wire logic       lpf_hiz_o,
    input  wire logic       pd_track_en_o,
    input  wire logic       out_align_en_o,
    input  wire logic       genlock_mode_o,
    input  wire logic       reference_loss_o,
    input  wire logic       lock_loss_o,
    input  wire logic       lor_event_o,
    input  wire logic       relock_event_o,
    input  wire logic [2:0] state_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    logic lor_st;
    assign lor_st = (state_o == 3'h3) || (state_o == 3'h4);

    // --------------------------------------------------------
    // checks
    // --------------------------------------------------------
    chk_mode_follow: assert property (1'b1 |=> genlock_mode_o == ($past(mode_source_select_i) ?
        $past(lock_mode_bit_i) : !$past(mode_select_pin_n_i))) else $error("mode source wrong");
    chk_free_off: assert property (!genlock_mode_o |-> state_o == 3'h0) else $error("free mode state");
    chk_bias_switch: assert property (free_bias_sw_o == (state_o == 3'h0 || state_o == 3'h3))
        else $error("bias switch wrong");
    chk_hold_hiz: assert property (lpf_hiz_o == (state_o == 3'h4)) else $error("hold hiz wrong");
    chk_track_gen: assert property (pd_track_en_o == (state_o == 3'h1 || state_o == 3'h2))
        else $error("tracking wrong");
    chk_align_lock: assert property (out_align_en_o |-> state_o == 3'h2 && $past(pll_locked_i))
        else $error("align without lock");
    chk_loss_flags: assert property (lor_st |-> reference_loss_o && lock_loss_o)
        else $error("loss flags wrong");
    chk_lock_flags: assert property (state_o == 3'h2 |-> !reference_loss_o && !lock_loss_o)
        else $error("lock flags wrong");
    chk_lor_event: assert property (lor_event_o |-> lor_st && !$past(lor_st))
        else $error("loss event wrong");
    chk_relock_event: assert property (relock_event_o |-> state_o == 3'h1 && $past(lor_st))
        else $error("relock event wrong");
endmodule
`default_nettype wire

// >>> verif/gmc_sync_source.sv
// Purpose: external h sync source for ports a and b
// Assumes: gated-off port rests low, as behind a pull-down
// Notes:   port b pulses are offset half a period from port a
`timescale 1ns/1ps
`default_nettype none
module gmc_sync_source #(parameter int PERIOD = 64) (
    input  wire logic mclk_i,
    input  wire logic en_a_i,
    input  wire logic en_b_i,
    output var logic  hsync_a_o = 1'b0,
    output var logic  hsync_b_o = 1'b0
);
    logic [7:0] cnt_reg = 8'h00;
    always_ff @(posedge mclk_i) begin
        cnt_reg   <= (cnt_reg == 8'(PERIOD - 1)) ? 8'h00 : cnt_reg + 8'h01;
        hsync_a_o <= en_a_i && (cnt_reg < 8'h02);
        hsync_b_o <= en_b_i && (cnt_reg >= 8'h20) && (cnt_reg < 8'h22);
    end
endmodule
`default_nettype wire

// >>> verif/test_genlock_mode_control.sv
// Purpose: self-checking bench for gmc_top
// Assumes: 25 MHz clock, hsync period far below the loss window
// Notes:   mode table first, then lock, loss and relock cases
`timescale 1ns/1ps
`default_nettype none
module test_genlock_mode_control;
    import gmc_pkg::*;
    typedef struct packed {logic src, mbit, pin_n, mode; logic [2:0] st;} gmc_row_s;
    logic mclk = 1'b0, srst = 1'b1, mbit = 1'b0, src = 1'b1, pin_n = 1'b1, hold = 1'b0;
    logic psel = 1'b0, locked = 1'b0, en_a = 1'b1, en_b = 1'b0;
    logic [1:0] herr = 2'h0;
    wire logic hs_a, hs_b, bias, hiz, track, pdh, align, gmode, rloss, lloss, lev, rev;
    wire logic [2:0] st;
    int fail_count = 0, comparisons = 0, cycles = 0, n;
    int lev_cnt = 0, rev_cnt = 0, pdh_cnt = 0;
    gmc_row_s rows [7] = '{'{1,0,1,0,0}, '{1,1,1,1,1}, '{1,1,0,1,1}, '{0,1,1,0,0},
                           '{0,0,0,1,1}, '{0,1,0,1,1}, '{1,0,0,0,0}};

    always #20 mclk = ~mclk;
    gmc_sync_source #(.PERIOD(64)) i_src (.mclk_i(mclk), .en_a_i(en_a), .en_b_i(en_b),
        .hsync_a_o(hs_a), .hsync_b_o(hs_b));
    gmc_top i_dut (.mclk_i(mclk), .srst_i(srst), .lock_mode_bit_i(mbit),
        .mode_source_select_i(src), .mode_select_pin_n_i(pin_n), .hold_on_loss_i(hold),
        .hsync_a_i(hs_a), .hsync_b_i(hs_b), .ref_port_sel_i(psel), .h_error_i(herr),
        .pll_locked_i(locked), .free_bias_sw_o(bias), .lpf_hiz_o(hiz), .pd_track_en_o(track),
        .pd_hsync_o(pdh), .out_align_en_o(align), .genlock_mode_o(gmode),
        .reference_loss_o(rloss), .lock_loss_o(lloss), .lor_event_o(lev),
        .relock_event_o(rev), .state_o(st));

    task automatic chk(input string what, input logic [2:0] exp, input logic [2:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
            fail_count++;
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    // bounded wait; the hardware gives no completion strobe for state moves
    task automatic wait_st(input logic [2:0] s, input int lim, output int cnt);
        cnt = 0;
        while (st !== s && cnt < lim) begin
            tick(1);
            cnt++;
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // --------------------------------------------------------
    // hang guard, roughly twice the expected run
    // --------------------------------------------------------
    // one-cycle outputs are counted where they stand
    always @(posedge mclk) begin
        if (!srst && lev === 1'b1) lev_cnt++;
        if (!srst && rev === 1'b1) rev_cnt++;
        if (!srst && pdh === 1'b1) pdh_cnt++;
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            wrap_up();
        end
    end

    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial begin
        tick(12);
        chk("reset state", 3'h0, st);
        chk("reset bias", 3'h1, {2'h0, bias});
        chk("reset flags", 3'h3, {1'b0, rloss, lloss});
        @(posedge mclk) srst <= 1'b0;
        // first h sync edge after reset may be one full period away
        tick(70);
        chk("ref clears", 3'h0, {2'h0, rloss});
        $display("test reset done");
        foreach (rows[i]) begin
            @(posedge mclk);
            src <= rows[i].src;
            mbit <= rows[i].mbit;
            pin_n <= rows[i].pin_n;
            tick(3);
            chk("mode", {2'h0, rows[i].mode}, {2'h0, gmode});
            chk("state", rows[i].st, st);
            chk("track", {2'h0, rows[i].mode}, {2'h0, track});
            chk("bias", {2'h0, !rows[i].mode}, {2'h0, bias});
        end
        $display("test mode table done");
        @(posedge mclk) begin
            mbit <= 1'b1;
            locked <= 1'b1;
        end
        wait_st(3'h2, 400, n);
        chk("lock settle", 3'h1, {2'h0, n >= LOCK_SETTLE_CYC - 2});
        chk("align", 3'h1, {2'h0, align});
        @(posedge mclk) locked <= 1'b0;
        wait_st(3'h1, 10, n);
        chk("lock drop", 3'h5, {lloss, 1'b0, track});
        $display("test lock done");
        @(posedge mclk) en_a <= 1'b0;
        wait_st(3'h3, 8000, n);
        // last edge may precede the drop by up to one h sync period
        chk("loss h0 time", 3'h1, {2'h0, n >= 2400 && n <= 2600});
        chk("loss free", 3'h3, {1'b0, bias, rloss});
        @(posedge mclk) en_a <= 1'b1;
        wait_st(3'h1, 100, n);
        chk("relock", 3'h1, {2'h0, track});
        chk("relock bias", 3'h0, {2'h0, bias});
        $display("test loss free done");
        @(posedge mclk) begin
            herr <= 2'h1;
            hold <= 1'b1;
            en_a <= 1'b0;
        end
        wait_st(3'h4, 9000, n);
        chk("loss h1 time", 3'h1, {2'h0, n >= 4900 && n <= 5100});
        chk("hold hiz", 3'h2, {1'b0, hiz, bias});
        @(posedge mclk) begin
            psel <= 1'b1;
            en_b <= 1'b1;
        end
        wait_st(3'h1, 100, n);
        chk("port b relock", 3'h1, st);
        $display("test hold done");
        @(posedge mclk) en_b <= 1'b0;
        wait_st(3'h4, 9000, n);
        @(posedge mclk) mbit <= 1'b0;
        tick(3);
        chk("free in loss", 3'h0, st);
        chk("free bias", 3'h0, {1'b0, hiz, !bias});
        chk("loss events", 3'h3, lev_cnt[2:0]);
        chk("relock events", 3'h2, rev_cnt[2:0]);
        chk("pd hsync seen", 3'h1, {2'h0, pdh_cnt > 0});
        $display("test free mode done");
        wrap_up();
    end
endmodule

bind gmc_top gmc_top_asserts u_chk (.mclk_i(mclk_i), .srst_i(srst_i),
    .lock_mode_bit_i(lock_mode_bit_i), .mode_source_select_i(mode_source_select_i),
    .mode_select_pin_n_i(mode_select_pin_n_i), .pll_locked_i(pll_locked_i),
    .free_bias_sw_o(free_bias_sw_o), .lpf_hiz_o(lpf_hiz_o), .pd_track_en_o(pd_track_en_o),
    .out_align_en_o(out_align_en_o), .genlock_mode_o(genlock_mode_o),
    .reference_loss_o(reference_loss_o), .lock_loss_o(lock_loss_o),
    .lor_event_o(lor_event_o), .relock_event_o(relock_event_o), .state_o(state_o));
`default_nettype wire
